// File: pkg/atp_pkg.sv
/*
 Constants and carrier types for the converter control block.
 Assumes a 25 MHz system clock and an AXI4-Lite register bus.
*/
`default_nettype none
package atp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL0 = 8'h00;
   localparam logic [7:0] OFF_CTRL1 = 8'h04;
   localparam logic [7:0] OFF_CTRL2 = 8'h08;
   localparam logic [7:0] OFF_RES_HI = 8'h0c;
   localparam logic [7:0] OFF_RES_LO = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFF_PORT = 8'h1c;
   localparam logic [7:0] OFF_DIR = 8'h20;
   localparam logic [7:0] OFF_CMP_MODE = 8'h24;
   // Control zero fields
   localparam int CTRL0_ENABLE = 0;
   localparam int CTRL0_GO = 1;
   localparam int CTRL0_CHS_LO = 2;
   // Control two fields
   localparam int CTRL2_ACQ_LO = 3;
   localparam int CTRL2_JUSTIFY = 7;
   // Reset values and the trigger mode code
   localparam logic [3:0] PCFG_RST_ANALOG = 4'h0;
   localparam logic [3:0] PCFG_RST_DIGITAL = 4'h7;
   localparam logic [12:0] DIR_RST = 13'h1fff;
   localparam logic [3:0] TRIG_MODE = 4'hb;
   // System clocks per converter clock period and conversion length
   localparam logic [3:0] TAD_CYCLES = 4'h4;
   localparam logic [4:0] CONV_TADS = 5'h0d;
   // Interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_TRIG = 1;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {ST_IDLE, ST_ACQ, ST_CONV} atp_state_t;

   typedef struct packed {
      logic trig;
      logic [3:0] mode;
   } atp_cmp_t;

   typedef struct packed {
      logic timer_clear;
      logic start;
   } atp_evt_t;
endpackage
`default_nettype wire

// File: hw/atp_sar.sv
/*
 Successive-approximation sequencer: one bit per converter clock period.
 Assumes the comparator input is a level already in the clock domain.
*/
`default_nettype none
module atp_sar #(
   parameter int WIDTH = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic step,
   input wire logic cmp_hi,
   output logic [WIDTH-1:0] dac,
   output logic done,
   output logic [WIDTH-1:0] result
);
   typedef struct packed {
      logic busy;
      logic [WIDTH-1:0] trial;
      logic [WIDTH-1:0] bitm;
      logic done;
   } atp_sar_t;
   atp_sar_t s_r, s_nxt;

   // Bit test and keep
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (start)
      begin
         s_nxt.busy = 1'b1;
         s_nxt.bitm = {1'b1, {(WIDTH-1){1'b0}}};
         s_nxt.trial = {1'b1, {(WIDTH-1){1'b0}}};
      end
      else if (s_r.busy && step)
      begin
         if (!cmp_hi)
            s_nxt.trial = s_r.trial & ~s_r.bitm;
         s_nxt.bitm = s_r.bitm >> 1;
         s_nxt.trial = s_nxt.trial | (s_r.bitm >> 1);
         if (s_r.bitm[0])
         begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign dac = s_r.trial;
   assign result = s_r.trial;
   assign done = s_r.done;
endmodule
`default_nettype wire

// File: hw/atp_top.sv
/*
 Converter control: register file over AXI4-Lite, pin qualification,
 compare-unit trigger handling, acquisition timing and the result pair.
 Assumes the pin levels and comparator arrive asynchronously and the
 compare unit and timers run on the same clock.
*/
`default_nettype none
module atp_top #(
   parameter int NPINS = 13,
   parameter int RES_W = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic analog_reset_strap,
   input wire logic [NPINS-1:0] pin_level,
   input wire logic comparator_hi,
   input wire atp_pkg::atp_cmp_t compare_in,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [RES_W-1:0] dac_code,
   output logic [3:0] sample_channel,
   output logic sample_close,
   output atp_pkg::atp_evt_t event_out,
   output logic irq
);
   typedef struct packed {
      logic [3:0] chs;
      logic go;
      logic en;
      logic [1:0] vref;
      logic [3:0] pcfg;
      logic justify;
      logic [2:0] acqt;
      logic [2:0] adcs;
      logic [RES_W-1:0] res;
      logic [1:0] ista;
      logic [1:0] imask;
      logic [NPINS-1:0] dir;
      logic [3:0] cmp_mode;
      atp_pkg::atp_state_t st;
      logic [4:0] tads;
      logic [3:0] div;
      logic strap_take;
      logic [NPINS-1:0] pin_s1, pin_s2;
      logic cmp_s1, cmp_s2;
      logic aw_ok, w_ok;
      logic [7:0] aw_a;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic bvalid, arready, rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp, bresp;
      logic sar_start;
      atp_pkg::atp_evt_t evt;
      logic irq;
      logic close;
   } atp_top_t;
   atp_top_t s_r, s_nxt;

   logic [RES_W-1:0] sar_result;
   logic sar_done;

   // Acquisition length in converter clock periods
   function automatic logic [4:0] acq_tads(input logic [2:0] code);
      case (code)
         3'h0: acq_tads = 5'h00;
         3'h1: acq_tads = 5'h02;
         3'h2: acq_tads = 5'h04;
         3'h3: acq_tads = 5'h06;
         3'h4: acq_tads = 5'h08;
         3'h5: acq_tads = 5'h0c;
         3'h6: acq_tads = 5'h10;
         default: acq_tads = 5'h14;
      endcase
   endfunction

   // Pin configured as analog for a field value
   function automatic logic is_analog(input logic [3:0] pcfg,
                                      input int idx);
      is_analog = (idx < 13) && (32'(idx) + 32'(pcfg) < 32'd15);
   endfunction

   // Conversion sequencer
   atp_sar #(
      .WIDTH(RES_W)
   ) u_sar (
      .clock(clock),
      .rst(rst),
      .start(s_r.sar_start),
      .step(s_r.st == atp_pkg::ST_CONV && s_r.div == '0),
      .cmp_hi(s_r.cmp_s2),
      .dac(dac_code),
      .done(sar_done),
      .result(sar_result)
   );

   // Next-state logic
   always_comb
   begin
      logic trig_mode;
      logic accept;
      logic [NPINS-1:0] port_rd;
      logic [31:0] rd;
      trig_mode = 1'b0;
      accept = 1'b0;
      port_rd = '0;
      rd = '0;
      s_nxt = s_r;
      s_nxt.pin_s1 = pin_level;
      s_nxt.pin_s2 = s_r.pin_s1;
      s_nxt.cmp_s1 = comparator_hi;
      s_nxt.cmp_s2 = s_r.cmp_s1;
      s_nxt.sar_start = 1'b0;
      s_nxt.evt = '0;
      s_nxt.strap_take = 1'b0;
      // Strap caught once after reset release
      if (s_r.strap_take)
         s_nxt.pcfg = analog_reset_strap ? atp_pkg::PCFG_RST_ANALOG
                                         : atp_pkg::PCFG_RST_DIGITAL;

      // AXI write capture
      if (s_axi_awvalid && !s_r.aw_ok && !s_r.bvalid)
      begin
         s_nxt.aw_ok = 1'b1;
         s_nxt.aw_a = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && !s_r.w_ok && !s_r.bvalid)
      begin
         s_nxt.w_ok = 1'b1;
         s_nxt.w_d = s_axi_wdata;
         s_nxt.w_s = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready)
         s_nxt.bvalid = 1'b0;

      // Converter clock divider, counting in every state and restarted on entry to acquisition and conversion
      s_nxt.div = (s_r.div == atp_pkg::TAD_CYCLES - 4'h1) ? 4'h0
                : s_r.div + 4'h1;

      // Sequencer: channel and direction never gate progress
      case (s_r.st)
         atp_pkg::ST_IDLE:
            if (s_r.go)
            begin
               s_nxt.tads = acq_tads(s_r.acqt);
               s_nxt.div = '0;
               s_nxt.st = atp_pkg::ST_ACQ;
               s_nxt.close = acq_tads(s_r.acqt) != 5'h00;
            end
         atp_pkg::ST_ACQ:
            if (s_r.tads == '0 || (s_r.tads == 5'h01
                && s_r.div == atp_pkg::TAD_CYCLES - 4'h1))
            begin
               s_nxt.st = atp_pkg::ST_CONV;
               s_nxt.close = 1'b0;
               s_nxt.sar_start = 1'b1;
               s_nxt.div = '0;
            end
            else if (s_r.div == atp_pkg::TAD_CYCLES - 4'h1)
               s_nxt.tads = s_r.tads - 5'h01;
         atp_pkg::ST_CONV:
            if (sar_done)
            begin
               s_nxt.res = sar_result;
               s_nxt.go = 1'b0;
               s_nxt.ista[atp_pkg::IRQ_DONE] = 1'b1;
               s_nxt.st = atp_pkg::ST_IDLE;
            end
         default: s_nxt.st = atp_pkg::ST_IDLE;
      endcase
      if (!s_r.en)
      begin
         s_nxt.st = atp_pkg::ST_IDLE;
         s_nxt.go = 1'b0;
         s_nxt.close = 1'b0;
      end

      // Compare unit special event trigger
      trig_mode = compare_in.mode == atp_pkg::TRIG_MODE;
      if (compare_in.trig && trig_mode)
      begin
         s_nxt.evt.timer_clear = 1'b1;
         accept = s_r.en && !s_r.go && s_r.st == atp_pkg::ST_IDLE;
         if (accept)
         begin
            s_nxt.go = 1'b1;
            s_nxt.evt.start = 1'b1;
            s_nxt.ista[atp_pkg::IRQ_TRIG] = 1'b1;
         end
      end

      // Register write, status set wins over clear
      if (s_r.aw_ok && s_r.w_ok)
      begin
         s_nxt.aw_ok = 1'b0;
         s_nxt.w_ok = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = atp_pkg::RESP_OKAY;
         if (s_r.w_s[0])
            case (s_r.aw_a)
               atp_pkg::OFF_CTRL0:
               begin
                  s_nxt.en = s_r.w_d[atp_pkg::CTRL0_ENABLE];
                  s_nxt.chs = s_r.w_d[atp_pkg::CTRL0_CHS_LO +: 4];
                  if (s_r.w_d[atp_pkg::CTRL0_GO]
                      && s_r.w_d[atp_pkg::CTRL0_ENABLE])
                     s_nxt.go = 1'b1;
               end
               atp_pkg::OFF_CTRL1:
               begin
                  s_nxt.pcfg = s_r.w_d[3:0];
                  s_nxt.vref = s_r.w_d[5:4];
               end
               atp_pkg::OFF_CTRL2:
               begin
                  s_nxt.adcs = s_r.w_d[2:0];
                  s_nxt.acqt = s_r.w_d[atp_pkg::CTRL2_ACQ_LO +: 3];
                  s_nxt.justify = s_r.w_d[atp_pkg::CTRL2_JUSTIFY];
               end
               atp_pkg::OFF_IRQ_STAT:
                  s_nxt.ista = s_nxt.ista & ~(s_r.w_d[1:0] & ~(
                     {s_nxt.ista[1] & ~s_r.ista[1],
                      s_nxt.ista[0] & ~s_r.ista[0]}));
               atp_pkg::OFF_IRQ_MASK: s_nxt.imask = s_r.w_d[1:0];
               atp_pkg::OFF_DIR: s_nxt.dir = s_r.w_d[NPINS-1:0];
               atp_pkg::OFF_CMP_MODE: s_nxt.cmp_mode = s_r.w_d[3:0];
               atp_pkg::OFF_RES_HI, atp_pkg::OFF_RES_LO,
               atp_pkg::OFF_PORT: ;
               default: s_nxt.bresp = atp_pkg::RESP_SLVERR;
            endcase
      end

      // Port read masks analog pins
      for (int i = 0; i < NPINS; i++)
         port_rd[i] = is_analog(s_r.pcfg, i) ? 1'b0 : s_r.pin_s2[i];

      // AXI read
      s_nxt.arready = 1'b0;
      if (s_r.rvalid && s_axi_rready)
         s_nxt.rvalid = 1'b0;
      if (s_axi_arvalid && !s_r.rvalid && !s_r.arready)
      begin
         s_nxt.arready = 1'b1;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = atp_pkg::RESP_OKAY;
         case (s_axi_araddr[7:0])
            atp_pkg::OFF_CTRL0: rd = {26'h0, s_r.chs, s_r.go, s_r.en};
            atp_pkg::OFF_CTRL1: rd = {26'h0, s_r.vref, s_r.pcfg};
            atp_pkg::OFF_CTRL2:
               rd = {24'h0, s_r.justify, 1'b0, s_r.acqt, s_r.adcs};
            atp_pkg::OFF_RES_HI:
               rd = s_r.justify ? {24'h0, 4'h0, s_r.res[11:8]}
                                : {24'h0, s_r.res[11:4]};
            atp_pkg::OFF_RES_LO:
               rd = s_r.justify ? {24'h0, s_r.res[7:0]}
                                : {24'h0, s_r.res[3:0], 4'h0};
            atp_pkg::OFF_IRQ_STAT: rd = {30'h0, s_r.ista};
            atp_pkg::OFF_IRQ_MASK: rd = {30'h0, s_r.imask};
            atp_pkg::OFF_PORT: rd = 32'(port_rd);
            atp_pkg::OFF_DIR: rd = 32'(s_r.dir);
            atp_pkg::OFF_CMP_MODE: rd = {28'h0, s_r.cmp_mode};
            default: s_nxt.rresp = atp_pkg::RESP_SLVERR;
         endcase
         s_nxt.rdata = rd;
      end

      s_nxt.irq = |(s_nxt.ista & s_nxt.imask);
   end

   // State register; reset turns the converter off
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.dir <= atp_pkg::DIR_RST;
         s_r.pcfg <= atp_pkg::PCFG_RST_ANALOG;
         s_r.strap_take <= 1'b1;
         s_r.st <= atp_pkg::ST_IDLE;
      end
      else
         s_r <= s_nxt;
   end

   // Outputs; the multiplexer passes the selected pin whatever drives it
   assign s_axi_awready = s_r.aw_ok;
   assign s_axi_wready = s_r.w_ok;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign sample_channel = s_r.chs;
   assign sample_close = s_r.close;
   assign event_out = s_r.evt;
   assign irq = s_r.irq;
endmodule
`default_nettype wire

// File: verification/atp_far_model.sv
/*
 Far side: compare unit trigger, pin levels and the analog comparator.
 Assumes the caller steps fire right after a rising clock edge.
*/
`default_nettype none
module atp_far_model #(
   parameter logic [11:0] VIN = 12'h5a3,
   parameter logic [12:0] PINS = 13'h1fff
) (
   input wire logic clock,
   input wire logic [11:0] dac_code,
   output var atp_pkg::atp_cmp_t compare_in,
   output logic comparator_hi,
   output logic [12:0] pin_level
);
   timeunit 1ns;
   timeprecision 1ns;
   initial compare_in = '0;
   // Input sits half a step above VIN
   assign comparator_hi = {VIN, 1'b1} > {dac_code, 1'b0};
   assign pin_level = PINS;
   // One-cycle special event with its mode field
   task automatic fire(input logic [3:0] m);
      compare_in <= '{trig: 1'b1, mode: m};
      @(posedge clock);
      compare_in.trig <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verification/atp_top_chk.sv
/*
 Port assertions for the converter control block.
 Assumes it is bound into atp_top; one clock, async reset.
*/
`default_nettype none
module atp_top_chk (
   input wire logic clock,
   input wire logic rst,
   input wire atp_pkg::atp_cmp_t compare_in,
   input wire atp_pkg::atp_evt_t event_out,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   logic hit;
   // Qualified trigger from the compare unit
   assign hit = compare_in.trig && compare_in.mode == atp_pkg::TRIG_MODE;
   trig_clear_a: assert property (hit |=> event_out.timer_clear)
      else $error("timer not cleared");
   stray_clear_a: assert property (!hit |=> !event_out.timer_clear)
      else $error("stray timer clear");
   start_pair_a: assert property (event_out.start |-> event_out.timer_clear)
      else $error("start without clear");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("bvalid dropped");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> $stable(s_axi_rvalid)) else $error("rvalid dropped");
   read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid
      |=> s_axi_arready && s_axi_rvalid) else $error("read late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid &&
      !s_axi_awready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
      else $error("write late");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready too long");
   // Main scenarios
   cover property (event_out.start);
   cover property (hit && !compare_in.mode[2]);
   cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind atp_top atp_top_chk i_atp_top_chk (.clock(clock), .rst(rst),
   .compare_in(compare_in), .event_out(event_out),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));
`default_nettype wire

// File: verification/atp_top_test.sv
/*
 Self-checking bench for the converter control block.
 Assumes the far-side model and the bound checker.
*/
`default_nettype none
module atp_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rst = 1, strap = 1;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
   logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, cmp_hi, close, irq;
   logic [1:0] bresp, rresp;
   logic [11:0] dac;
   logic [3:0] chan, chan_seen;
   logic [12:0] pins;
   atp_pkg::atp_cmp_t cmp;
   atp_pkg::atp_evt_t ev;
   int bad_count = 0, n_compared = 0, n_start = 0, n_clear = 0, acq = 0;
   int tads[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   always #20 clock = ~clock;
   atp_top i_atp_top (.clock(clock), .rst(rst), .analog_reset_strap(strap),
      .pin_level(pins), .comparator_hi(cmp_hi), .compare_in(cmp),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dac_code(dac),
      .sample_channel(chan), .sample_close(close), .event_out(ev),
      .irq(irq));
   atp_far_model i_atp_far_model (.clock(clock), .dac_code(dac),
      .compare_in(cmp), .comparator_hi(cmp_hi), .pin_level(pins));
   // Event counts and acquisition length
   always @(posedge clock)
   begin
      if (ev.start)
         n_start <= n_start + 1;
      if (ev.timer_clear)
         n_clear <= n_clear + 1;
      if (close)
      begin
         acq <= acq + 1;
         chan_seen <= chan;
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      awaddr <= {24'h0, a};
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
         if (awready)
            awv <= 1'b0;
         if (wready)
            wv <= 1'b0;
      end while (bvalid !== 1'b1 && n < 99);
      bready <= 1'b0;
      chk("bresp", {1'b1, atp_pkg::RESP_OKAY}, {bvalid, bresp});
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [2:0] r);
      int n = 0;
      araddr <= {24'h0, a};
      arv <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
         if (arready === 1'b1 && rvalid !== 1'b1)
            arv <= 1'b0;
      end while (rvalid !== 1'b1 && n < 99);
      d = rdata;
      r = {rvalid, rresp};
      arv <= 1'b0;
      rready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = atp_pkg::RESP_OKAY);
      logic [31:0] d;
      logic [2:0] r;
      rd(a, d, r);
      chk("rdata", e, d);
      chk("rresp", {1'b1, er}, r);
   endtask
   // Poll until the go bit falls
   task automatic wait_done();
      logic [31:0] d;
      logic [2:0] r;
      int n = 0;
      do
      begin
         rd(atp_pkg::OFF_CTRL0, d, r);
         n++;
      end while (d[atp_pkg::CTRL0_GO] !== 1'b0 && n < 99);
      chk("go", 0, d[atp_pkg::CTRL0_GO]);
   endtask
   task automatic do_reset(input logic s);
      rst <= 1'b1;
      strap <= s;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
   endtask
   task automatic test_done();
      if (bad_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      do_reset(1'b1);
      rc(atp_pkg::OFF_CTRL1, 0);
      rc(atp_pkg::OFF_CTRL0, 0);
      rc(atp_pkg::OFF_DIR, 32'h1fff);
      rc(8'h40, 0, atp_pkg::RESP_SLVERR);
      wr(atp_pkg::OFF_CTRL2, 32'hff);
      rc(atp_pkg::OFF_CTRL2, 32'hbf);
      rc(atp_pkg::OFF_PORT, 0);
      wr(atp_pkg::OFF_CTRL1, 32'h7);
      rc(atp_pkg::OFF_PORT, 32'h1f00);
      wr(atp_pkg::OFF_DIR, 0);
      i_atp_far_model.fire(atp_pkg::TRIG_MODE);
      rc(atp_pkg::OFF_CTRL0, 0);
      chk("clears", 1, n_clear);
      wr(atp_pkg::OFF_CTRL0, 32'h1);
      i_atp_far_model.fire(4'ha);
      rc(atp_pkg::OFF_CTRL0, 32'h1);
      chk("clears", 1, n_clear);
      for (int c = 0; c < 8; c++)
      begin
         int a0;
         wr(atp_pkg::OFF_CTRL2, 32'h80 | (c << atp_pkg::CTRL2_ACQ_LO));
         wr(atp_pkg::OFF_CTRL0, (c << atp_pkg::CTRL0_CHS_LO) | 1);
         a0 = acq;
         i_atp_far_model.fire(atp_pkg::TRIG_MODE);
         @(posedge clock);
         i_atp_far_model.fire(atp_pkg::TRIG_MODE);
         wait_done();
         chk("acq", tads[c] * int'(atp_pkg::TAD_CYCLES), acq - a0);
         if (c > 0)
            chk("chan", c, chan_seen);
         chk("starts", c + 1, n_start);
         chk("clears", 2 * c + 3, n_clear);
         rc(atp_pkg::OFF_RES_HI, 32'h05);
         rc(atp_pkg::OFF_RES_LO, 32'ha3);
      end
      // Left-justified view of the same result
      wr(atp_pkg::OFF_CTRL2, 32'h38);
      rc(atp_pkg::OFF_RES_HI, 32'h5a);
      rc(atp_pkg::OFF_RES_LO, 32'h30);
      rc(atp_pkg::OFF_IRQ_STAT, 32'h3);
      chk("irq", 0, irq);
      wr(atp_pkg::OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clock);
      chk("irq", 1, irq);
      wr(atp_pkg::OFF_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clock);
      chk("irq", 0, irq);
      wr(atp_pkg::OFF_DIR, 32'h1fff);
      rc(atp_pkg::OFF_DIR, 32'h1fff);
      i_atp_far_model.fire(atp_pkg::TRIG_MODE);
      repeat (10) @(posedge clock);
      chk("close", 1, close);
      do_reset(1'b0);
      chk("close", 0, close);
      rc(atp_pkg::OFF_CTRL0, 0);
      rc(atp_pkg::OFF_CTRL1, 32'h7);
      test_done();
   end
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clock);
      bad_count++;
      test_done();
   end
endmodule
`default_nettype wire
